// ==== design/ftd_top.sv ====
// Purpose: Fan tachometers, fan DAC code and temperature comparator
// Assumes: APB slave with zero wait states, sensor word on temp_raw_i
// Notes: Scan period is a parameter so simulation can shorten it
`timescale 1ns/1ps
`default_nettype none
module ftd_top #(
    parameter int SCAN_CYC = ftd_pkg::SCAN_CYC,
    parameter int FILT_LEN = 8
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Fans and DAC
    input wire logic tach_in_a_i,
    input wire logic tach_in_b_i,
    input wire logic dac_overdrive_i,
    output logic [7:0] fan_drive_out_o,
    // Temperature and test mode
    input wire logic [11:0] temp_raw_i,
    output logic temp_over_o,
    output logic temp_under_o,
    output logic temp_crit_o,
    output logic test_mode_o
);
    localparam int STEP_CYC = SCAN_CYC / ftd_pkg::SCAN_ITEMS;
    if (STEP_CYC < 2) $error("SCAN_CYC too small");

    logic start_ff, ext_ff, init_ff, tick_ff, upd_ff, test_ff;
    logic [10:0] ref_ff;
    logic [31:0] step_ff;
    logic [3:0] item_ff;
    logic [1:0] div_a_ff, div_b_ff;
    logic [7:0] fan_a_ff, fan_b_ff, meas_a, meas_b, dac_ff;
    logic [7:0] high_ff, release_ff, low_ff, crit_ff;
    logic [2:0] hyst_ff;
    logic [11:0] temp_ff;
    logic over_ff, under_ff, critf_ff;
    logic wr_w, rd_setup, hit_w, item_end;
    logic [31:0] rd_mux;
    logic signed [12:0] rdg;

    // Align a 9-bit signed degree value to the reading LSB
    function automatic logic signed [12:0] align(input logic signed [8:0] v,
                                                  input logic ext);
        logic signed [12:0] w;
        w = 13'(v);
        align = ext ? (w <<< 4) : (w <<< 1);
    endfunction : align

    function automatic logic signed [8:0] sx(input logic [7:0] v);
        sx = 9'(signed'(v));
    endfunction : sx

    // APB decode; test mode answers nothing useful
    assign pready = psel & penable;
    assign wr_w = psel & penable & pwrite & ~test_ff & ~pslverr;
    assign rd_setup = psel & ~penable & ~pwrite;
    always_comb begin
        hit_w = 1'b1;
        rd_mux = 32'h0000_0000;
        unique case (paddr)
            ftd_pkg::OFS_CONFIG: rd_mux = 32'({ext_ff, start_ff});
            ftd_pkg::OFS_DIVISOR: rd_mux = 32'({div_b_ff, div_a_ff, 4'h0});
            ftd_pkg::OFS_FAN_A: rd_mux = 32'(fan_a_ff);
            ftd_pkg::OFS_FAN_B: rd_mux = 32'(fan_b_ff);
            ftd_pkg::OFS_DAC: rd_mux = 32'(dac_ff);
            ftd_pkg::OFS_TEMP: rd_mux = 32'(temp_ff);
            ftd_pkg::OFS_T_HIGH: rd_mux = 32'(high_ff);
            ftd_pkg::OFS_T_RELEASE: rd_mux = 32'(release_ff);
            ftd_pkg::OFS_T_LOW: rd_mux = 32'(low_ff);
            ftd_pkg::OFS_T_CRIT: rd_mux = 32'(crit_ff);
            ftd_pkg::OFS_TEMP_HYSTERESIS_OFFSET: rd_mux = 32'(hyst_ff);
            ftd_pkg::OFS_STATUS: rd_mux = 32'({test_ff, critf_ff, under_ff, over_ff});
            default: hit_w = 1'b0;
        endcase
    end
    assign pslverr = psel & penable & (~hit_w | paddr[1:0] != 2'h0 | test_ff);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prdata <= 32'h0000_0000;
        end else if (rd_setup) begin
            prdata <= test_ff ? 32'h0000_0000 : rd_mux;
        end
    end

    // Overdrive latch; only reset leaves test mode
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            test_ff <= 1'b0;
        end else if (dac_overdrive_i) begin
            test_ff <= 1'b1;
        end
    end
    assign test_mode_o = test_ff;

    // DAC code survives soft init on purpose
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dac_ff <= ftd_pkg::DAC_RST;
        end else if (wr_w && paddr == ftd_pkg::OFS_DAC) begin
            dac_ff <= pwdata[7:0];
        end
    end
    assign fan_drive_out_o = dac_ff;

    // Config, divisors and setpoints
    always_ff @(posedge clk_i) begin
        init_ff <= 1'b0;
        if (rst_i || init_ff) begin
            start_ff <= 1'b0;
            ext_ff <= 1'b0;
            div_a_ff <= ftd_pkg::DIV_RST;
            div_b_ff <= ftd_pkg::DIV_RST;
            high_ff <= ftd_pkg::T_HIGH_RST;
            release_ff <= ftd_pkg::T_RELEASE_RST;
            low_ff <= ftd_pkg::T_LOW_RST;
            crit_ff <= ftd_pkg::T_CRIT_RST;
            hyst_ff <= ftd_pkg::TEMP_HYSTERESIS_OFFSET_RST;
        end else if (wr_w) begin
            unique case (paddr)
                ftd_pkg::OFS_CONFIG: begin
                    start_ff <= pwdata[ftd_pkg::CFG_START];
                    ext_ff <= pwdata[ftd_pkg::CFG_EXT];
                    init_ff <= pwdata[ftd_pkg::CFG_INIT];
                end
                ftd_pkg::OFS_DIVISOR: begin
                    div_a_ff <= pwdata[ftd_pkg::DIV_A_LSB +: 2];
                    div_b_ff <= pwdata[ftd_pkg::DIV_B_LSB +: 2];
                end
                ftd_pkg::OFS_T_HIGH: high_ff <= pwdata[7:0];
                ftd_pkg::OFS_T_RELEASE: release_ff <= pwdata[7:0];
                ftd_pkg::OFS_T_LOW: low_ff <= pwdata[7:0];
                ftd_pkg::OFS_T_CRIT: crit_ff <= pwdata[7:0];
                ftd_pkg::OFS_TEMP_HYSTERESIS_OFFSET: hyst_ff <= pwdata[2:0];
                default: ;
            endcase
        end
    end

    // 22.5 kHz reference enable
    always_ff @(posedge clk_i) begin
        if (rst_i || ref_ff == 11'(ftd_pkg::REF_DIV - 1)) begin
            ref_ff <= 11'h000;
            tick_ff <= ~rst_i;
        end else begin
            ref_ff <= ref_ff + 11'h001;
            tick_ff <= 1'b0;
        end
    end

    ftd_tach #(.FILT_LEN(FILT_LEN)) u_tach_a (
        .clk_i(clk_i), .rst_i(rst_i), .ref_tick_i(tick_ff),
        .div_sel_i(div_a_ff), .tach_i(tach_in_a_i), .meas_o(meas_a));
    ftd_tach #(.FILT_LEN(FILT_LEN)) u_tach_b (
        .clk_i(clk_i), .rst_i(rst_i), .ref_tick_i(tick_ff),
        .div_sel_i(div_b_ff), .tach_i(tach_in_b_i), .meas_o(meas_b));

    // Round-robin scan; voltage items are slots with no work here
    assign item_end = step_ff == 32'(STEP_CYC - 1);
    always_ff @(posedge clk_i) begin
        if (rst_i || init_ff || !start_ff || test_ff) begin
            step_ff <= 32'h0000_0000;
            item_ff <= ftd_pkg::STEP_TEMP;
        end else if (item_end) begin
            step_ff <= 32'h0000_0000;
            item_ff <= (item_ff == ftd_pkg::STEP_FAN_B) ? ftd_pkg::STEP_TEMP
                                                       : item_ff + 4'h1;
        end else begin
            step_ff <= step_ff + 32'h0000_0001;
        end
    end

    // Results captured at the end of the temperature and fan item slots
    always_ff @(posedge clk_i) begin
        upd_ff <= 1'b0;
        if (rst_i || init_ff) begin
            fan_a_ff <= 8'h00;
            fan_b_ff <= 8'h00;
            temp_ff <= 12'h000;
        end else if (start_ff && !test_ff && item_end) begin
            if (item_ff == ftd_pkg::STEP_FAN_A) begin
                fan_a_ff <= meas_a;
            end
            if (item_ff == ftd_pkg::STEP_FAN_B) begin
                fan_b_ff <= meas_b;
            end
            if (item_ff == ftd_pkg::STEP_TEMP) begin
                upd_ff <= 1'b1;
                temp_ff <= ext_ff ? temp_raw_i
                                  : {{3{temp_raw_i[11]}}, temp_raw_i[11:3]};
            end
        end
    end

    // Comparator on the fresh reading
    assign rdg = 13'(signed'(temp_ff));
    always_ff @(posedge clk_i) begin
        if (rst_i || init_ff) begin
            over_ff <= 1'b0;
            under_ff <= 1'b0;
            critf_ff <= 1'b0;
        end else if (upd_ff) begin
            if (rdg > align(sx(high_ff), ext_ff)) begin
                over_ff <= 1'b1;
            end else if (!ext_ff && rdg <= align(sx(release_ff), ext_ff)) begin
                over_ff <= 1'b0;
            end else if (ext_ff
                && rdg <= align(sx(high_ff) - 9'(hyst_ff), ext_ff)) begin
                over_ff <= 1'b0;
            end
            // Normal mode has no low or critical limit
            if (!ext_ff) begin
                under_ff <= 1'b0;
                critf_ff <= 1'b0;
            end else begin
                if (rdg <= align(sx(low_ff), ext_ff)) begin
                    under_ff <= 1'b1;
                end else if (rdg > align(sx(low_ff) + 9'(hyst_ff), ext_ff)) begin
                    under_ff <= 1'b0;
                end
                if (rdg > align(sx(crit_ff), ext_ff)) begin
                    critf_ff <= 1'b1;
                end else if (rdg <= align(sx(crit_ff) - 9'(hyst_ff), ext_ff)) begin
                    critf_ff <= 1'b0;
                end
            end
        end
    end
    assign temp_over_o = over_ff;
    assign temp_under_o = under_ff;
    assign temp_crit_o = critf_ff;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_init_write;
        wr_w && paddr == ftd_pkg::OFS_CONFIG && pwdata[ftd_pkg::CFG_INIT];
    endsequence
    sequence s_init_done;
        init_ff ##1 !init_ff;
    endsequence
    a_dac_full_reset: assert property (disable iff (1'b0)
        rst_i |=> dac_ff == 8'hFF) else $error("dac not full scale");
    a_init_keeps_dac: assert property (s_init_write ##1 s_init_done
        |-> dac_ff == $past(dac_ff, 2)) else $error("dac lost on init");
    a_init_div_two: assert property (s_init_write |=> ##1 div_a_ff == 2'h1
        && div_b_ff == 2'h1) else $error("divisor not default");
    a_fan_refresh: assert property (start_ff && !test_ff && item_end
        && item_ff == ftd_pkg::STEP_FAN_B && !init_ff
        |=> fan_b_ff == $past(meas_b)) else $error("fan b not refreshed");
    a_temp_nine_bit: assert property (upd_ff && !$past(ext_ff)
        |-> temp_ff == {{3{$past(temp_raw_i[11])}}, $past(temp_raw_i[11:3])})
        else $error("bad 9-bit reading");
    a_ext_reading: assert property (upd_ff && $past(ext_ff)
        |-> temp_ff == $past(temp_raw_i)) else $error("bad 12-bit reading");
    a_over_sets: assert property (upd_ff && rdg > align(sx(high_ff), ext_ff)
        && !init_ff |=> over_ff) else $error("over not set");
    a_norm_quiet: assert property (upd_ff && !ext_ff && !init_ff
        |=> !under_ff && !critf_ff) else $error("flags set in normal mode");
    a_under_sets: assert property (upd_ff && ext_ff && !init_ff
        && rdg <= align(sx(low_ff), ext_ff) |=> under_ff) else $error("under not set");
    a_crit_release: assert property (upd_ff && ext_ff && !init_ff
        && rdg <= align(sx(crit_ff) - 9'(hyst_ff), ext_ff)
        |=> !critf_ff) else $error("crit not released");
    a_test_blocks: assert property (test_ff |=> $stable(dac_ff) && test_ff)
        else $error("write in test mode");
    a_read_blank: assert property (rd_setup && test_ff
        |=> prdata == 32'h0000_0000) else $error("data shown in test mode");
    a_drive_tracks: assert property (wr_w && paddr == ftd_pkg::OFS_DAC
        |=> fan_drive_out_o == $past(pwdata[7:0])) else $error("drive not updated");
endmodule : ftd_top
`default_nettype wire

// ==== design/ftd_pkg.sv ====
// Purpose: Shared constants of the fan, DAC and temperature datapath
// Assumes: 25 MHz system clock, APB register access
// Notes: Byte offsets of 32-bit registers
package ftd_pkg;
    localparam int CLK_HZ = 25_000_000;
    localparam int REF_HZ = 22_500;
    localparam int REF_DIV = CLK_HZ / REF_HZ;
    localparam int SCAN_MS = 400;
    localparam int SCAN_CYC = CLK_HZ / 1000 * SCAN_MS;
    localparam int SCAN_ITEMS = 9;
    localparam logic [3:0] STEP_TEMP = 4'h0;
    localparam logic [3:0] STEP_FAN_A = 4'h7;
    localparam logic [3:0] STEP_FAN_B = 4'h8;
    localparam logic [7:0] CNT_MAX = 8'hFF;
    // Register byte offsets
    localparam logic [7:0] OFS_CONFIG = 8'h00;
    localparam logic [7:0] OFS_DIVISOR = 8'h04;
    localparam logic [7:0] OFS_FAN_A = 8'h08;
    localparam logic [7:0] OFS_FAN_B = 8'h0C;
    localparam logic [7:0] OFS_DAC = 8'h10;
    localparam logic [7:0] OFS_TEMP = 8'h14;
    localparam logic [7:0] OFS_T_HIGH = 8'h18;
    localparam logic [7:0] OFS_T_RELEASE = 8'h1C;
    localparam logic [7:0] OFS_T_LOW = 8'h20;
    localparam logic [7:0] OFS_T_CRIT = 8'h24;
    localparam logic [7:0] OFS_TEMP_HYSTERESIS_OFFSET = 8'h28;
    localparam logic [7:0] OFS_STATUS = 8'h2C;
    // Field positions
    localparam int CFG_START = 0;
    localparam int CFG_EXT = 1;
    localparam int CFG_INIT = 7;
    localparam int DIV_A_LSB = 4;
    localparam int DIV_B_LSB = 6;
    // Reset values
    localparam logic [1:0] DIV_RST = 2'h1;
    localparam logic [7:0] DAC_RST = 8'hFF;
    localparam logic [7:0] T_HIGH_RST = 8'h46;
    localparam logic [7:0] T_RELEASE_RST = 8'h41;
    localparam logic [7:0] T_LOW_RST = 8'h00;
    localparam logic [7:0] T_CRIT_RST = 8'h64;
    localparam logic [2:0] TEMP_HYSTERESIS_OFFSET_RST = 3'h2;
endpackage : ftd_pkg

// ==== design/ftd_tach.sv ====
// Purpose: One tachometer period counter
// Assumes: ref_tick_i is a one-cycle 22.5 kHz enable
// Notes: Count saturates at 255 and is reported at once
`timescale 1ns/1ps
`default_nettype none
module ftd_tach #(
    parameter int FILT_LEN = 8
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Timing and control
    input wire logic ref_tick_i,
    input wire logic [1:0] div_sel_i,
    // Tachometer
    input wire logic tach_i,
    // Result
    output logic [7:0] meas_o
);
    if (FILT_LEN < 2 || FILT_LEN > 255) $error("FILT_LEN out of range");
    logic sync1_ff, sync2_ff, filt_ff, prev_ff, armed_ff;
    logic [7:0] stab_ff;
    logic [1:0] pre_ff;
    logic [8:0] cnt_ff;
    logic [8:0] nxt_cnt;
    logic edge_w, step_w;

    always_ff @(posedge clk_i) begin
        sync1_ff <= tach_i;
        sync2_ff <= sync1_ff;
    end

    // Slow edges chatter; level must hold FILT_LEN cycles
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stab_ff <= 8'h00;
            // Pulled-up idle level, so reset makes no false edge
            filt_ff <= 1'b1;
            prev_ff <= 1'b1;
        end else begin
            prev_ff <= filt_ff;
            if (sync2_ff == filt_ff) begin
                stab_ff <= 8'h00;
            end else if (stab_ff == 8'(FILT_LEN - 1)) begin
                filt_ff <= sync2_ff;
                stab_ff <= 8'h00;
            end else begin
                stab_ff <= stab_ff + 8'h01;
            end
        end
    end
    assign edge_w = filt_ff & ~prev_ff;

    // Divisor 1 counts twice per tick, 2 once, 4 and 8 skip ticks
    always_comb begin
        unique case (div_sel_i)
            2'h0: step_w = 1'b1;
            2'h1: step_w = 1'b1;
            2'h2: step_w = pre_ff[0];
            2'h3: step_w = &pre_ff;
        endcase
        nxt_cnt = cnt_ff;
        if (ref_tick_i && step_w) begin
            nxt_cnt = cnt_ff + ((div_sel_i == 2'h0) ? 9'h002 : 9'h001);
        end
        if (nxt_cnt > {1'b0, ftd_pkg::CNT_MAX}) begin
            nxt_cnt = {1'b0, ftd_pkg::CNT_MAX};
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_ff <= 9'h000;
            pre_ff <= 2'h0;
            armed_ff <= 1'b0;
            meas_o <= 8'h00;
        end else if (edge_w) begin
            cnt_ff <= 9'h000;
            pre_ff <= 2'h0;
            armed_ff <= 1'b1;
            if (armed_ff) begin
                meas_o <= cnt_ff[7:0];
            end
        end else begin
            cnt_ff <= nxt_cnt;
            if (ref_tick_i) begin
                pre_ff <= pre_ff + 2'h1;
            end
            if (cnt_ff[7:0] == ftd_pkg::CNT_MAX) begin
                meas_o <= ftd_pkg::CNT_MAX;
            end
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_sat_report: assert property (cnt_ff[7:0] == ftd_pkg::CNT_MAX && !edge_w
        |=> meas_o == ftd_pkg::CNT_MAX) else $error("no saturated report");
    a_edge_single: assert property (edge_w |=> !edge_w [*2])
        else $error("edge repeated");
    a_count_bound: assert property (cnt_ff <= 9'h0FF)
        else $error("counter past max");
endmodule : ftd_tach
`default_nettype wire

// ==== test/ftd_fan_model.sv ====
// Purpose: Fan side model, two tach outputs and the drive pin overdrive
// Assumes: Open-collector tach lines with pull-ups
// Notes: Period in clock cycles; a zero period stops the fan
`timescale 1ns/1ps
`default_nettype none
module ftd_fan_model (
    // Clock
    input wire logic clk_i,
    // Control
    input wire logic [31:0] per_a_i,
    input wire logic [31:0] per_b_i,
    input wire logic glitch_i,
    input wire logic over_req_i,
    // Fan side
    output logic tach_a_o,
    output logic tach_b_o,
    output logic overdrive_o
);
    logic [31:0] cnt_a = 32'h0;
    logic [31:0] cnt_b = 32'h0;
    always @(posedge clk_i) begin
        cnt_a <= (cnt_a + 32'h1 >= per_a_i) ? 32'h0 : cnt_a + 32'h1;
        cnt_b <= (cnt_b + 32'h1 >= per_b_i) ? 32'h0 : cnt_b + 32'h1;
    end
    // Pull-up holds a stopped fan high; short dropout mimics a noisy edge
    assign tach_a_o = (per_a_i == 32'h0) || ((cnt_a < per_a_i / 2) && !(glitch_i &&
        cnt_a >= per_a_i / 4 && cnt_a < per_a_i / 4 + 3));
    assign tach_b_o = (per_b_i == 32'h0) || (cnt_b < per_b_i / 2);
    // Amplifier pulls the pin high only when told to
    assign overdrive_o = over_req_i;
endmodule : ftd_fan_model
`default_nettype wire

// ==== test/test_fan_tach_temp_dac_datapath.sv ====
// Purpose: Self-checking bench of the fan, DAC and temperature datapath
// Assumes: Zero-wait APB, scan shortened to 90 cycles
// Notes: Fan counts checked within two counts, reference tick phase is free
`timescale 1ns/1ps
`default_nettype none
module test_fan_tach_temp_dac_datapath;
    localparam int SCAN = 90;
    localparam int TICKS = 20;
    localparam int PER = TICKS * ftd_pkg::REF_DIV;
    // Count of a fan at 70% of nominal speed, default divisor
    localparam int FAIL_CNT = 219;
    typedef struct packed {
        logic wr;
        logic [7:0] addr;
        logic [31:0] data;
        logic [31:0] exp;
        logic err;
    } ftd_row_t;
    typedef struct packed {
        logic ext;
        logic [11:0] raw;
        logic [11:0] tmp;
        logic [2:0] flg;
    } ftd_trow_t;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic tach_a;
    logic tach_b;
    logic overdrive;
    logic [7:0] fan_drive;
    logic [11:0] temp_raw = 12'h000;
    logic t_over;
    logic t_under;
    logic t_crit;
    logic test_mode;
    logic [31:0] per = 32'h0;
    logic glitch = 1'b0;
    logic over_req = 1'b0;
    int n_fail = 0;
    int check_count = 0;
    logic [31:0] q;
    logic e;
    // Reset values first, then writes with readback, last an unmapped read that must error; table rows are tagged
    ftd_row_t rows [15] = '{
        '{1'b0, ftd_pkg::OFS_DIVISOR, 32'h0, 32'h50, 1'b0},
        '{1'b0, ftd_pkg::OFS_DAC, 32'h0, 32'hFF, 1'b0},
        '{1'b0, ftd_pkg::OFS_T_HIGH, 32'h0, 32'h46, 1'b0},
        '{1'b0, ftd_pkg::OFS_T_RELEASE, 32'h0, 32'h41, 1'b0},
        '{1'b0, ftd_pkg::OFS_T_LOW, 32'h0, 32'h00, 1'b0},
        '{1'b0, ftd_pkg::OFS_T_CRIT, 32'h0, 32'h64, 1'b0},
        '{1'b0, ftd_pkg::OFS_TEMP_HYSTERESIS_OFFSET, 32'h0, 32'h02, 1'b0},
        '{1'b0, ftd_pkg::OFS_FAN_A, 32'h0, 32'h00, 1'b0},
        '{1'b1, ftd_pkg::OFS_T_HIGH, 32'h7D, 32'h7D, 1'b0},
        '{1'b1, ftd_pkg::OFS_T_LOW, 32'hD8, 32'hD8, 1'b0},
        '{1'b1, ftd_pkg::OFS_TEMP_HYSTERESIS_OFFSET, 32'hFF, 32'h07, 1'b0},
        '{1'b1, ftd_pkg::OFS_DAC, 32'hFF, 32'hFF, 1'b0},
        '{1'b1, ftd_pkg::OFS_DAC, 32'h80, 32'h80, 1'b0},
        '{1'b1, ftd_pkg::OFS_DIVISOR, 32'h80, 32'h80, 1'b0},
        '{1'b0, 8'h30, 32'h0, 32'h00, 1'b1}};
    // Setpoint 25 C; flags are {crit, under, over}
    ftd_trow_t trows [7] = '{
        '{1'b0, 12'h190, 12'h032, 3'h0},
        '{1'b0, 12'h198, 12'h033, 3'h1},
        '{1'b0, 12'h191, 12'h032, 3'h0},
        '{1'b1, 12'h191, 12'h191, 3'h1},
        '{1'b1, 12'h180, 12'h180, 3'h1},
        '{1'b1, 12'hD80, 12'hD80, 3'h2},
        '{1'b1, 12'h7D0, 12'h7D0, 3'h5}};
    ftd_top #(.SCAN_CYC(SCAN), .FILT_LEN(8)) dut_u (
        .clk_i(clk_i), .rst_i(rst_i), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .tach_in_a_i(tach_a),
        .tach_in_b_i(tach_b), .dac_overdrive_i(overdrive),
        .fan_drive_out_o(fan_drive), .temp_raw_i(temp_raw), .temp_over_o(t_over),
        .temp_under_o(t_under), .temp_crit_o(t_crit), .test_mode_o(test_mode));
    ftd_fan_model fan_u (
        .clk_i(clk_i), .per_a_i(per), .per_b_i(per), .glitch_i(glitch),
        .over_req_i(over_req), .tach_a_o(tach_a), .tach_b_o(tach_b),
        .overdrive_o(overdrive));
    initial begin
        forever #20 clk_i = ~clk_i;
    end
    task automatic close_out;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : close_out
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
            n_fail++;
        end
    endtask : chk
    // Tachometer counts may land two counts either way of the ideal
    task automatic chk_near(input logic [31:0] got, input int exp);
        check_count++;
        if ($isunknown(got) || got + 2 < exp || got > exp + 2) begin
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
            n_fail++;
        end
    endtask : chk_near
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
    endtask : cyc
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic er);
        int n;
        @(posedge clk_i);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_i);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (pready !== 1'b1 && n < 8);
        if (pready !== 1'b1) begin
            $display("unexpected at %0t got %h exp %h", $time, pready, 1'b1);
            n_fail++;
            close_out();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    initial begin
        cyc(2);
        rst_i <= 1'b0;
        foreach (rows[i]) begin
            if (rows[i].wr) begin
                apb(1'b1, rows[i].addr, rows[i].data, q, e);
                chk({31'h0, e}, {31'h0, rows[i].err});
            end
            apb(1'b0, rows[i].addr, 32'h0, q, e);
            chk(q, rows[i].exp);
            chk({31'h0, e}, {31'h0, rows[i].err});
            if (rows[i].wr && rows[i].addr == ftd_pkg::OFS_DAC) begin
                chk({24'h0, fan_drive}, rows[i].exp);
            end
        end
        $display("test registers done");
        apb(1'b1, ftd_pkg::OFS_DAC, 32'h33, q, e);
        apb(1'b1, ftd_pkg::OFS_CONFIG, 32'h80, q, e);
        apb(1'b0, ftd_pkg::OFS_DAC, 32'h0, q, e);
        chk(q, 32'h33);
        apb(1'b0, ftd_pkg::OFS_T_HIGH, 32'h0, q, e);
        chk(q, 32'h46);
        $display("test soft init done");
        apb(1'b1, ftd_pkg::OFS_T_HIGH, 32'h19, q, e);
        foreach (trows[i]) begin
            temp_raw <= trows[i].raw;
            apb(1'b1, ftd_pkg::OFS_CONFIG, {30'h0, trows[i].ext, 1'b1}, q, e);
            cyc(2 * SCAN + 10);
            apb(1'b0, ftd_pkg::OFS_TEMP, 32'h0, q, e);
            chk(q, {20'h0, trows[i].tmp});
            chk({29'h0, t_crit, t_under, t_over}, {29'h0, trows[i].flg});
            apb(1'b0, ftd_pkg::OFS_STATUS, 32'h0, q, e);
            chk({28'h0, q[3:0]}, {29'h0, trows[i].flg});
        end
        $display("test temperature done");
        // Fan B stands for a one-pulse fan, so software doubles its divisor
        apb(1'b1, ftd_pkg::OFS_DIVISOR, 32'h80, q, e);
        apb(1'b1, ftd_pkg::OFS_CONFIG, 32'h01, q, e);
        per <= PER;
        glitch <= 1'b1;
        cyc(2 * PER + 2 * SCAN);
        apb(1'b0, ftd_pkg::OFS_FAN_A, 32'h0, q, e);
        chk_near(q, 1350000 / ((ftd_pkg::REF_HZ * 30 / TICKS) * 1));
        apb(1'b0, ftd_pkg::OFS_FAN_B, 32'h0, q, e);
        chk_near(q, 1350000 / ((ftd_pkg::REF_HZ * 60 / TICKS) * 4 / 2));
        // Both fans two-pulse again: default divisor on A, largest on B
        apb(1'b1, ftd_pkg::OFS_DIVISOR, 32'hD0, q, e);
        cyc(2 * PER + 2 * SCAN);
        apb(1'b0, ftd_pkg::OFS_FAN_A, 32'h0, q, e);
        chk_near(q, 1350000 / ((ftd_pkg::REF_HZ * 30 / TICKS) * 2));
        chk({31'h0, q >= FAIL_CNT}, 32'h0);
        apb(1'b0, ftd_pkg::OFS_FAN_B, 32'h0, q, e);
        chk_near(q, 1350000 / ((ftd_pkg::REF_HZ * 30 / TICKS) * 8));
        $display("test fans done");
        over_req <= 1'b1;
        cyc(10);
        chk({31'h0, test_mode}, 32'h1);
        apb(1'b1, ftd_pkg::OFS_DAC, 32'h11, q, e);
        chk({31'h0, e}, 32'h1);
        apb(1'b0, ftd_pkg::OFS_DAC, 32'h0, q, e);
        chk({31'h0, e}, 32'h1);
        chk(q, 32'h0);
        chk({24'h0, fan_drive}, 32'h33);
        over_req <= 1'b0;
        rst_i <= 1'b1;
        cyc(2);
        rst_i <= 1'b0;
        cyc(1);
        chk({31'h0, test_mode}, 32'h0);
        chk({24'h0, fan_drive}, 32'hFF);
        apb(1'b0, ftd_pkg::OFS_DIVISOR, 32'h0, q, e);
        chk(q, 32'h50);
        $display("test overdrive and reset done");
        close_out();
    end
endmodule : test_fan_tach_temp_dac_datapath
`default_nettype wire
